// ===== include/mmdec_regs.svh
`ifndef MMDEC_REGS_SVH
`define MMDEC_REGS_SVH
// ----------------------------------------
// Address map boundaries
// ----------------------------------------
`define MMDEC_WIN_LO      16'h0000
`define MMDEC_WIN_HI      16'h006f
`define MMDEC_RAM_LO      16'h0070
`define MMDEC_RAM_HI      16'h046f
`define MMDEC_EXT_LO      16'h0470
`define MMDEC_EXT_HI      16'h7fff
`define MMDEC_TST0_LO     16'h8000
`define MMDEC_TST0_HI     16'h807f
`define MMDEC_ROM_LO      16'h8080
`define MMDEC_ROM_HI      16'hfffb
`define MMDEC_TST1_LO     16'hfffc
`define MMDEC_TST1_HI     16'hffff
// Short-address page bases
`define MMDEC_ZERO_PAGE   8'h00
`define MMDEC_SPEC_PAGE   8'hff
// Port and direction registers, external in expansion mode
`define MMDEC_PORT_LO     16'h0008
`define MMDEC_PORT_HI     16'h000f
// Mode register A address and reset value
`define MMDEC_MODE_A_ADDR 16'h0000
`define MMDEC_MODE_A_RST  8'h0c
// Mode field position
`define MMDEC_MODE_LSB    0
`define MMDEC_MODE_MSB    1
`endif

// ===== include/mmdec_pkg.sv
package mmdec_pkg;
	// Processor mode, as held in the low two bits of mode register A
	typedef enum logic [1:0] {
		MMDEC_SINGLE   = 2'h0,
		MMDEC_EXPAND   = 2'h1,
		MMDEC_MICRO    = 2'h2,
		MMDEC_MICRO_B  = 2'h3
	} mmdec_mode_t;
	// Addressing form of the access
	typedef enum logic [1:0] {
		MMDEC_ABS      = 2'h0,
		MMDEC_ZP       = 2'h1,
		MMDEC_SP       = 2'h2
	} mmdec_amode_t;
endpackage

// ===== hdl/mmdec_decoder.sv
`timescale 1ns/1ps
`include "mmdec_regs.svh"
// Functional notes
// - 0000-006F selects peripheral register window
// - 0070-046F selects internal RAM
// - Overlaid RAM reads come from internal RAM
// - Expansion/microprocessor: overlaid RAM writes go to both
// - Single-chip: 0470-7FFF selects nothing
// - Expansion/microprocessor: 0470-7FFF goes external
// - Factory test areas select nothing, except in microprocessor mode, where they go external
// - 8080-FFFB selects internal ROM
// - Microprocessor mode sends ROM range external
// - First 256 addresses form zero page
// - FF00-FFFF forms the special page
// - Short address byte expanded to full
// - Mode register A bits 1:0 set mode
// - Boot pin high forces microprocessor mode bit
// - Expansion mode: port addresses go external
module mmdec_decoder (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        boot_mode_pin,
	input  wire logic        cpu_req,
	input  wire logic        cpu_wr,
	input  wire logic [1:0]  cpu_amode,
	input  wire logic [15:0] cpu_addr,
	input  wire logic [7:0]  cpu_wdata,
	output logic             sel_window,
	output logic             sel_ram,
	output logic             sel_rom,
	output logic             sel_ext,
	output logic             ext_wr,
	output logic             sel_none,
	output logic [15:0]      full_addr,
	output logic             in_zero_page,
	output logic             in_spec_page,
	output logic [1:0]       proc_mode
);

	// ----------------------------------------
	// Boot pin synchroniser
	// ----------------------------------------
	logic       boot_s1_q;          // First stage, read only by stage two
	logic       boot_s2_q;          // Synchronised boot level
	logic       boot_s1_d;
	logic       boot_s2_d;
	logic       boot_seen_q;        // Strap taken once after reset release
	logic       boot_seen_d;
	logic [1:0] mode_q;             // Mode register A low bits
	logic [1:0] mode_d;
	logic [15:0] addr_c;            // Full 16-bit address of this access

	// Synchroniser next values
	always_comb begin
		boot_s1_d = boot_mode_pin;
		boot_s2_d = boot_s1_q;
	end

	// ----------------------------------------
	// Mode register
	// ----------------------------------------
	// Strap is sampled after release since async-style capture of a pin is unsafe
	always_comb begin
		mode_d      = mode_q;
		boot_seen_d = 1'b1;
		if (!boot_seen_q && boot_s2_q) begin
			mode_d = 2'(mmdec_pkg::MMDEC_MICRO);
		end
		// software mode write
		// Short forms that expand to the mode register address load it as well
		if (boot_seen_q && cpu_req && cpu_wr && addr_c == `MMDEC_MODE_A_ADDR) begin
			mode_d = cpu_wdata[`MMDEC_MODE_MSB:`MMDEC_MODE_LSB];
		end
		if (boot_s2_q) begin
			mode_d[1] = 1'b1;
		end
	end

	// Register stage for mode and synchroniser
	// Synchroniser keeps running through reset so the strap is settled at release
	always_ff @(posedge core_clk) begin
		boot_s1_q <= boot_s1_d;
		boot_s2_q <= boot_s2_d;
		if (!reset_n) begin
			boot_seen_q <= 1'b0;
			mode_q      <= 2'(`MMDEC_MODE_A_RST);
		end else begin
			boot_seen_q <= boot_seen_d;
			mode_q      <= mode_d;
		end
	end

	// ----------------------------------------
	// Address expansion and decode
	// ----------------------------------------
	logic        win_c, ram_c, rom_c, ext_c, none_c, extwr_c;
	logic        zp_c, sp_c;
	logic        expand_c, micro_c;

	// Combinational target decode; registered below so outputs come from flops
	always_comb begin
		unique case (cpu_amode)
			2'(mmdec_pkg::MMDEC_ZP): addr_c = {`MMDEC_ZERO_PAGE, cpu_addr[7:0]};
			2'(mmdec_pkg::MMDEC_SP): addr_c = {`MMDEC_SPEC_PAGE, cpu_addr[7:0]};
			default:                 addr_c = cpu_addr;
		endcase
		expand_c = (mode_q == 2'(mmdec_pkg::MMDEC_EXPAND));
		micro_c  = mode_q[1];
		zp_c = (addr_c[15:8] == `MMDEC_ZERO_PAGE);
		sp_c = (addr_c[15:8] == `MMDEC_SPEC_PAGE);
		win_c   = 1'b0;
		ram_c   = 1'b0;
		rom_c   = 1'b0;
		ext_c   = 1'b0;
		extwr_c = 1'b0;
		if (!cpu_req) begin
			// Idle cycle: nothing selected
		end else if (addr_c <= `MMDEC_WIN_HI) begin
			if (expand_c && addr_c >= `MMDEC_PORT_LO && addr_c <= `MMDEC_PORT_HI) begin
				ext_c   = 1'b1;
				extwr_c = cpu_wr;
			end else begin
				win_c = 1'b1;
			end
		end else if (addr_c <= `MMDEC_RAM_HI) begin
			ram_c = 1'b1;
			if ((expand_c || micro_c) && cpu_wr) begin
				ext_c   = 1'b1;
				extwr_c = 1'b1;
			end
			// reads stay internal, ext_c stays low
		end else if (addr_c <= `MMDEC_EXT_HI) begin
			if (expand_c || micro_c) begin
				ext_c   = 1'b1;
				extwr_c = cpu_wr;
			end
		end else if (addr_c >= `MMDEC_ROM_LO && addr_c <= `MMDEC_ROM_HI) begin
			if (micro_c) begin
				ext_c   = 1'b1;
				extwr_c = cpu_wr;
			end else begin
				rom_c = 1'b1;
			end
		end else if (micro_c) begin
			// test areas are only external in microprocessor mode
			ext_c   = 1'b1;
			extwr_c = cpu_wr;
		end
		none_c = cpu_req && !(win_c || ram_c || rom_c || ext_c);
	end

	// Output registers; one cycle of latency keeps outputs glitch free
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			sel_window   <= 1'b0;
			sel_ram      <= 1'b0;
			sel_rom      <= 1'b0;
			sel_ext      <= 1'b0;
			ext_wr       <= 1'b0;
			sel_none     <= 1'b0;
			full_addr    <= 16'h0000;
			in_zero_page <= 1'b0;
			in_spec_page <= 1'b0;
			proc_mode    <= 2'h0;
		end else begin
			sel_window   <= win_c;
			sel_ram      <= ram_c;
			sel_rom      <= rom_c;
			sel_ext      <= ext_c;
			ext_wr       <= extwr_c;
			sel_none     <= none_c;
			full_addr    <= addr_c;
			in_zero_page <= zp_c;
			in_spec_page <= sp_c;
			proc_mode    <= mode_q;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	window_select_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(cpu_req && addr_c <= `MMDEC_WIN_HI && !expand_c) |=> sel_window)
		else $error("window access not selected");
	ram_select_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(cpu_req && addr_c >= `MMDEC_RAM_LO && addr_c <= `MMDEC_RAM_HI) |=> sel_ram)
		else $error("ram access not selected");
	ram_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(cpu_req && !cpu_wr && addr_c >= `MMDEC_RAM_LO && addr_c <= `MMDEC_RAM_HI) |=> !sel_ext)
		else $error("overlaid ram read went external");
	ram_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(cpu_req && cpu_wr && mode_q != 2'h0 && addr_c >= `MMDEC_RAM_LO && addr_c <= `MMDEC_RAM_HI)
		|=> (sel_ram && sel_ext && ext_wr))
		else $error("overlaid ram write not doubled");
	single_unused_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(cpu_req && mode_q == 2'h0 && addr_c >= `MMDEC_EXT_LO && addr_c <= `MMDEC_EXT_HI) |=> sel_none)
		else $error("unused area selected in single-chip");
	ext_route_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(cpu_req && mode_q != 2'h0 && addr_c >= `MMDEC_EXT_LO && addr_c <= `MMDEC_EXT_HI) |=> sel_ext)
		else $error("external area not routed");
	rom_select_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(cpu_req && !mode_q[1] && addr_c >= `MMDEC_ROM_LO && addr_c <= `MMDEC_ROM_HI) |=> sel_rom)
		else $error("rom access not selected");
	micro_rom_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(cpu_req && mode_q[1] && addr_c >= `MMDEC_ROM_LO && addr_c <= `MMDEC_ROM_HI)
		|=> (sel_ext && !sel_rom))
		else $error("microprocessor rom access not external");
	short_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		(cpu_amode == 2'h2) |=> (full_addr[15:8] == 8'hff && in_spec_page))
		else $error("special page expansion wrong");
	boot_force_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		boot_s2_q |=> mode_q[1])
		else $error("boot pin did not hold mode bit");
	one_select_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		!(sel_ram && sel_ext) |-> $onehot0({sel_window, sel_ram, sel_rom, sel_ext, sel_none}))
		else $error("more than one target selected");
	access_select_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		cpu_req |=> (sel_window || sel_ram || sel_rom || sel_ext || sel_none))
		else $error("access left without a target");
endmodule

// ===== verification/mmdec_ext_bus_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// External bus model
// ----------------------------------------
module mmdec_ext_bus_model (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        sel_ext,
	input  wire logic        ext_wr,
	output logic      [15:0] wr_cnt_q
);
	logic [15:0] wr_cnt_d; // Next write count
	always_comb begin
		wr_cnt_d = wr_cnt_q;
		// A strobe without the select is no bus cycle
		if (sel_ext && ext_wr) begin
			wr_cnt_d = wr_cnt_q + 16'h0001;
		end
	end
	// Count register, cleared with the core
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wr_cnt_q <= 16'h0000;
		end else begin
			wr_cnt_q <= wr_cnt_d;
		end
	end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	// ----------------------------------------
	// Stimulus and expectation state
	// ----------------------------------------
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        boot_mode_pin = 1'b0;
	logic        cpu_req = 1'b0;
	logic        cpu_wr = 1'b0;
	logic [1:0]  cpu_amode = 2'h0;
	logic [15:0] cpu_addr = 16'h0000;
	logic [7:0]  cpu_wdata = 8'h00;
	logic [5:0]  sel;
	logic [15:0] full_addr, wr_cnt;
	logic        zp, sp;
	logic [1:0]  proc_mode, mode, pm_now, pm_q;
	logic [23:0] e_now, e_q; // Expected outputs, one cycle apart
	logic        chk, v_now, v_q;
	logic [31:0] q, r;
	logic [15:0] ra; // Random address before expansion
	int          errors, n_compared, n_ewr, seed = 54;
	// Edge cases of every region
	logic [15:0] corner [14] = '{16'h006f, 16'h0070, 16'h046f, 16'h0470, 16'h7fff, 16'h8000,
		16'h807f, 16'h8080, 16'hfffb, 16'hfffc, 16'hffff, 16'h0008, 16'h000f, 16'h0010};
	mmdec_decoder dut (.core_clk(core_clk), .reset_n(reset_n), .boot_mode_pin(boot_mode_pin),
		.cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_amode(cpu_amode), .cpu_addr(cpu_addr),
		.cpu_wdata(cpu_wdata), .sel_window(sel[5]), .sel_ram(sel[4]), .sel_rom(sel[3]),
		.sel_ext(sel[2]), .ext_wr(sel[1]), .sel_none(sel[0]), .full_addr(full_addr),
		.in_zero_page(zp), .in_spec_page(sp), .proc_mode(proc_mode));
	mmdec_ext_bus_model ext (.core_clk(core_clk), .reset_n(reset_n), .sel_ext(sel[2]),
		.ext_wr(sel[1]), .wr_cnt_q(wr_cnt));
	// ----------------------------------------
	// Clock, expectation pipe and checks
	// ----------------------------------------
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	// Answer lands one edge after the request is taken
	always @(posedge core_clk) begin
		e_q <= e_now;
		pm_q <= pm_now;
		v_q <= v_now;
	end
	// Look at the settled outputs halfway through the cycle
	always @(negedge core_clk) begin
		if (v_q) begin
			check({26'h0, sel}, {26'h0, e_q[23:18]});
			check({14'h0, zp, sp, full_addr}, {14'h0, e_q[17:0]});
			check({30'h0, proc_mode}, {30'h0, pm_q});
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	// Reference decode: six selects, page flags, expanded address
	function automatic logic [23:0] dec(logic [1:0] m, logic w, logic [1:0] am, logic [15:0] ad);
		logic [15:0] a;
		logic [5:0]  s;
		a = am == 2'h1 ? {8'h00, ad[7:0]} : am == 2'h2 ? {8'hff, ad[7:0]} : ad;
		if (a <= 16'h006f) s = (m == 2'h1 && a >= 16'h0008 && a <= 16'h000f) ? 6'h04 : 6'h20;
		else if (a <= 16'h046f) s = (m != 2'h0 && w) ? 6'h14 : 6'h10;
		else if (a <= 16'h7fff) s = m != 2'h0 ? 6'h04 : 6'h01;
		else if (a <= 16'h807f || a >= 16'hfffc) s = m[1] ? 6'h04 : 6'h01;
		else s = m[1] ? 6'h04 : 6'h08;
		s[1] = s[2] & w;
		return {s, a[15:8] == 8'h00, a[15:8] == 8'hff, a};
	endfunction
	// One bus cycle; mode follows a write that expands to 0000
	task automatic drv(input logic rq, input logic w, input logic [1:0] am, input logic [15:0] ad,
		input logic [7:0] wd);
		logic [23:0] e;
		@(posedge core_clk);
		e = dec(mode, w, am, ad);
		// Idle cycles select nothing, but address and page flags still follow the bus
		if (!rq) e[23:18] = 6'h00;
		cpu_req <= rq;
		cpu_wr <= w;
		cpu_amode <= am;
		cpu_addr <= ad;
		cpu_wdata <= wd;
		e_now <= e;
		pm_now <= mode;
		v_now <= chk;
		n_ewr += int'(e[19]);
		if (rq && w && e[15:0] == 16'h0000) mode = {wd[1] | boot_mode_pin, wd[0]};
	endtask
	// Reset with the strap at a given level; settle before checking
	task automatic rst(input logic p);
		chk = 1'b0;
		// Let the last pending answer be checked before reset clears the outputs
		drv(1'b0, 1'b0, 2'h0, 16'h0, 8'h0);
		boot_mode_pin <= p;
		reset_n <= 1'b0;
		repeat (9) drv(1'b0, 1'b0, 2'h0, 16'h0, 8'h0);
		reset_n <= 1'b1;
		mode = {p, 1'b0};
		n_ewr = 0;
		repeat (5) drv(1'b0, 1'b0, 2'h0, 16'h0, 8'h0);
		chk = 1'b1;
	endtask
	task automatic test_done();
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Hang guard, far beyond the expected run
	initial begin
		repeat (5000) @(posedge core_clk);
		errors++;
		test_done();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		rst(1'b0);
		// Every mode, every boundary, back to back reads and writes
		for (int m = 0; m < 4; m++) begin
			drv(1'b1, 1'b1, 2'h1, 16'h7700, 8'(m));
			foreach (corner[i]) begin
				drv(1'b1, 1'b0, 2'h0, corner[i], 8'h00);
				drv(1'b1, 1'b1, 2'h0, corner[i], 8'h5a);
			end
			drv(1'b1, 1'b0, 2'h1, 16'h5a6f, 8'h00);
			drv(1'b1, 1'b1, 2'h2, 16'h00fc, 8'h00);
			drv(1'b1, 1'b0, 2'h3, 16'hff00, 8'h00);
		end
		// Random traffic, mode register hit now and then
		repeat (600) begin
			r = $random(seed);
			q = $random(seed);
			ra = r[3:0] == 4'h0 ? 16'h0000 : q[15:0];
			// software keeps off reserved window offsets
			if (ra[7:0] inside {8'h1e, 8'h4b, 8'h4f, 8'h5f, [8'h65:8'h6b]}) ra[7:0] = 8'h6c;
			drv(r[4] | r[5], r[6], r[8:7], ra, q[23:16]);
		end
		repeat (3) drv(1'b0, 1'b0, 2'h0, 16'h0, 8'h0);
		check({16'h0, wr_cnt}, n_ewr);
		// Strap high: clearing bit one has no effect, ROM goes external
		rst(1'b1);
		drv(1'b1, 1'b1, 2'h0, 16'h0000, 8'h00);
		drv(1'b1, 1'b0, 2'h0, 16'h9000, 8'h00);
		drv(1'b1, 1'b1, 2'h1, 16'h0000, 8'h01);
		drv(1'b1, 1'b1, 2'h0, 16'h0100, 8'h00);
		drv(1'b1, 1'b0, 2'h2, 16'h0010, 8'h00);
		repeat (3) drv(1'b0, 1'b0, 2'h0, 16'h0, 8'h0);
		check({16'h0, wr_cnt}, n_ewr);
		rst(1'b0);
		test_done();
	end
endmodule
